//--- core/scss_defines.vh
`ifndef SCSS_DEFINES_VH
`define SCSS_DEFINES_VH

// ------------------------------------------------------------
// apb register map (byte addresses)
// ------------------------------------------------------------
`define SCSS_OFS_SPEED_ONE 12'h000
`define SCSS_OFS_SPEED_TWO 12'h004
`define SCSS_OFS_SPEED_THREE 12'h008
`define SCSS_OFS_MODE 12'h00C
`define SCSS_OFS_MAX_ANALOG 12'h010
`define SCSS_OFS_ANALOG_IN 12'h014
`define SCSS_OFS_COMMAND 12'h018
`define SCSS_OFS_STATUS 12'h01C
`define SCSS_OFS_TUNING 12'h020

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define SCSS_MODE_ZERO_BIT 0
`define SCSS_MODE_TORQUE_BIT 1
`define SCSS_TUNE_AUTO_BIT 4
`define SCSS_TUNE_LEVEL_MSB 3
`define SCSS_TUNE_LEVELS 4'hA
`define SCSS_RST_SPEED 32'h00000000
`define SCSS_RST_MAX_ANALOG 16'h0BB8
`define SCSS_RST_MODE 2'h0
`define SCSS_RST_TUNING 5'h00
`define SCSS_SPEED_MAX 32'sd60000
`define SCSS_SPEED_MIN -32'sd60000
`define SCSS_ANALOG_SPEED_MAX 16'h2710
`define SCSS_VOLT_FULL_SCALE 32'sd10000

`endif

//--- core/scss_speed_reg.v
`include "scss_defines.vh"
// ------------------------------------------------------------
// one signed internal speed setting, clamped on write
// ------------------------------------------------------------
module scss_speed_reg (
  input wire clk,
  input wire rst,
  input wire wr,
  input wire [31:0] wdata,
  output reg [31:0] value_q
);
  wire signed [31:0] w_s = wdata;

  // clamp to the legal setting range
  always @(posedge clk) begin
    if (rst) begin
      value_q <= `SCSS_RST_SPEED;
    end else if (wr) begin
      if (w_s > `SCSS_SPEED_MAX) begin
        value_q <= `SCSS_SPEED_MAX;
      end else if (w_s < `SCSS_SPEED_MIN) begin
        value_q <= `SCSS_SPEED_MIN;
      end else begin
        value_q <= wdata;
      end
    end
  end
endmodule

//--- core/scss_sync2.v
// ------------------------------------------------------------
// two flip-flop synchroniser for a pin level
// ------------------------------------------------------------
module scss_sync2 (
  input wire clk,
  input wire rst,
  input wire din,
  output reg dout
);
  reg meta_q;

  // first stage read only by second stage
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

//--- core/scss_top.v
// Behaviour
// (R1) selects 00 in analog mode: command from reference voltage
// (R2) selects 00 in zero mode: command forced to zero
// (R3) any select on: internal stored speed used regardless of mode
// (R4) code 01 first, 10 second, 11 third internal speed
// (R5) select value 0 means off, 1 means on
// (R6) new internal command applied only after a select change
// (R7) internal speeds signed, clamped to +-60000, unit 0.1 r/min
// (R8) host keeps analog reference within -10 V to +10 V
// (R9) same command serves as speed limit in torque modes
// (R10) source chosen from selects plus zero-mode setting
// (R11) host should enable smoothing filters when needed
// (R12) auto tuning has ten bandwidth levels; manual disables auxiliaries
// (R13) analog speed = voltage times max analog speed over 10
// (R14) command registered and held stable between select changes, except with selects 00 in analog mode, where it follows the reference
`include "scss_defines.vh"
module scss_top (
  input wire CLK,
  input wire SYS_RST,
  input wire [11:0] PADDR,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire SPEED_SELECT_BIT0,
  input wire SPEED_SELECT_BIT1,
  input wire signed [15:0] ANALOG_MV,
  output wire signed [31:0] SPEED_COMMAND,
  output wire signed [31:0] SPEED_LIMIT,
  output wire SPEED_COMMAND_VALID,
  output wire TORQUE_MODE,
  output wire AUTO_TUNE_ON,
  output wire [3:0] BANDWIDTH_LEVEL
);
  // ------------------------------------------------------------
  // synchronised select pins and sampled analog word
  // ------------------------------------------------------------
  wire sel0_s;
  wire sel1_s;
  reg [15:0] ana_meta_q;
  reg [15:0] ana_sync_q;
  reg [15:0] ana_hold_q;
  reg [15:0] ana_q;

  scss_sync2 u_sync0 (
    .clk(CLK),
    .rst(SYS_RST),
    .din(SPEED_SELECT_BIT0),
    .dout(sel0_s)
  );
  scss_sync2 u_sync1 (
    .clk(CLK),
    .rst(SYS_RST),
    .din(SPEED_SELECT_BIT1),
    .dout(sel1_s)
  );

  // analog word from converter, two stages, then taken only when
  // two successive samples agree, so a torn word never reaches the math
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ana_meta_q <= 16'h0000;
      ana_sync_q <= 16'h0000;
      ana_hold_q <= 16'h0000;
      ana_q <= 16'h0000;
    end else begin
      ana_meta_q <= ANALOG_MV;
      ana_sync_q <= ana_meta_q;
      ana_hold_q <= ana_sync_q;
      if (ana_sync_q == ana_hold_q) begin
        ana_q <= ana_hold_q;
      end
    end
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire wr_en = PSEL & PENABLE & PWRITE;
  wire rd_setup = PSEL & ~PENABLE & ~PWRITE;
  wire hit_one = (PADDR == `SCSS_OFS_SPEED_ONE);
  wire hit_two = (PADDR == `SCSS_OFS_SPEED_TWO);
  wire hit_three = (PADDR == `SCSS_OFS_SPEED_THREE);
  wire hit_mode = (PADDR == `SCSS_OFS_MODE);
  wire hit_max = (PADDR == `SCSS_OFS_MAX_ANALOG);
  wire hit_ana = (PADDR == `SCSS_OFS_ANALOG_IN);
  wire hit_cmd = (PADDR == `SCSS_OFS_COMMAND);
  wire hit_stat = (PADDR == `SCSS_OFS_STATUS);
  wire hit_tune = (PADDR == `SCSS_OFS_TUNING);
  wire hit_any = hit_one | hit_two | hit_three | hit_mode | hit_max |
    hit_ana | hit_cmd | hit_stat | hit_tune;

  // zero-wait-state slave, error on unmapped
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_any;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  wire [31:0] spd_one;
  wire [31:0] spd_two;
  wire [31:0] spd_three;
  reg [1:0] mode_q;
  reg [15:0] max_ana_q;
  reg [4:0] tune_q;

  // (R7) signed clamped settings
  scss_speed_reg u_spd_one (
    .clk(CLK),
    .rst(SYS_RST),
    .wr(wr_en & hit_one),
    .wdata(PWDATA),
    .value_q(spd_one)
  );
  scss_speed_reg u_spd_two (
    .clk(CLK),
    .rst(SYS_RST),
    .wr(wr_en & hit_two),
    .wdata(PWDATA),
    .value_q(spd_two)
  );
  scss_speed_reg u_spd_three (
    .clk(CLK),
    .rst(SYS_RST),
    .wr(wr_en & hit_three),
    .wdata(PWDATA),
    .value_q(spd_three)
  );

  // mode, max analog speed, tuning writes
  always @(posedge CLK) begin
    if (SYS_RST) begin
      mode_q <= `SCSS_RST_MODE;
      max_ana_q <= `SCSS_RST_MAX_ANALOG;
      tune_q <= `SCSS_RST_TUNING;
    end else begin
      if (wr_en & hit_mode) begin
        mode_q <= PWDATA[1:0];
      end
      if (wr_en & hit_max) begin
        if (PWDATA[15:0] > `SCSS_ANALOG_SPEED_MAX) begin
          max_ana_q <= `SCSS_ANALOG_SPEED_MAX;
        end else begin
          max_ana_q <= PWDATA[15:0];
        end
      end
      // (R12) ten levels, 0 to 9
      if (wr_en & hit_tune) begin
        tune_q[`SCSS_TUNE_AUTO_BIT] <= PWDATA[`SCSS_TUNE_AUTO_BIT];
        if (PWDATA[3:0] < `SCSS_TUNE_LEVELS) begin
          tune_q[3:0] <= PWDATA[3:0];
        end
      end
    end
  end

  wire zero_speed_mode = mode_q[`SCSS_MODE_ZERO_BIT];
  assign TORQUE_MODE = mode_q[`SCSS_MODE_TORQUE_BIT];
  // (R12) manual mode disables auto functions
  assign AUTO_TUNE_ON = tune_q[`SCSS_TUNE_AUTO_BIT];
  assign BANDWIDTH_LEVEL = tune_q[`SCSS_TUNE_AUTO_BIT] ?
    tune_q[3:0] : 4'h0;

  // ------------------------------------------------------------
  // analog scaling
  // ------------------------------------------------------------
  // (R13) mv * max / 10000 mv == volts * max / 10
  wire signed [16:0] max_s = {1'b0, max_ana_q};
  wire signed [32:0] ana_prod = $signed(ana_q) * max_s;
  wire signed [32:0] ana_div = ana_prod / 33'sd10000;
  // (R1) analog command in 0.1 r/min
  wire signed [31:0] ana_speed = $signed(ana_div[31:0]) * 32'sd10;

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  reg [1:0] sel_prev_q;
  reg signed [31:0] cmd_q;
  reg valid_q;
  // (R5) 1 on, 0 off
  wire [1:0] sel_now = {sel1_s, sel0_s};
  wire sel_change = (sel_now != sel_prev_q);
  reg signed [31:0] internal_pick;

  // (R4) code to internal speed mapping
  always @* begin
    case (sel_now)
      2'h1: internal_pick = spd_one;
      2'h2: internal_pick = spd_two;
      2'h3: internal_pick = spd_three;
      default: internal_pick = 32'h00000000;
    endcase
  end

  // (R14) registered command held between select changes, except with selects 00 in analog mode
  always @(posedge CLK) begin
    if (SYS_RST) begin
      sel_prev_q <= 2'h0;
      cmd_q <= 32'h00000000;
      valid_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_now;
      valid_q <= 1'b1;
      // (R10) selects plus mode choose source
      if (sel_now == 2'h0) begin
        // (R2) zero mode forces zero
        if (zero_speed_mode) begin
          cmd_q <= 32'h00000000;
        // (R1) analog mode follows reference
        end else begin
          cmd_q <= ana_speed;
        end
      // (R3) (R6) internal value taken on select change
      end else if (sel_change) begin
        cmd_q <= internal_pick;
      end
    end
  end

  // (R9) same command used as torque-mode limit
  assign SPEED_COMMAND = TORQUE_MODE ? 32'h00000000 : cmd_q;
  assign SPEED_LIMIT = TORQUE_MODE ? cmd_q : 32'h00000000;
  assign SPEED_COMMAND_VALID = valid_q;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  reg [31:0] rdata_q;

  // read data latched in setup phase
  always @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_q <= 32'h00000000;
    end else if (rd_setup) begin
      case (1'b1)
        hit_one: rdata_q <= spd_one;
        hit_two: rdata_q <= spd_two;
        hit_three: rdata_q <= spd_three;
        hit_mode: rdata_q <= {30'h00000000, mode_q};
        hit_max: rdata_q <= {16'h0000, max_ana_q};
        hit_ana: rdata_q <= {{16{ana_q[15]}}, ana_q};
        hit_cmd: rdata_q <= cmd_q;
        hit_stat: rdata_q <= {29'h00000000, valid_q, sel_now};
        hit_tune: rdata_q <= {27'h0000000, tune_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign PRDATA = rdata_q;
endmodule

//--- tb/scss_asserts.sv
// ----
// port checks for the selector
// ----
module scss_asserts (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SPEED_SELECT_BIT0,
  input wire logic SPEED_SELECT_BIT1,
  input wire logic signed [15:0] ANALOG_MV,
  input wire logic signed [31:0] SPEED_COMMAND,
  input wire logic signed [31:0] SPEED_LIMIT,
  input wire logic SPEED_COMMAND_VALID,
  input wire logic TORQUE_MODE,
  input wire logic AUTO_TUNE_ON,
  input wire logic [3:0] BANDWIDTH_LEVEL
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // select code and merged output, one side is always zero
  wire [1:0] sel = {SPEED_SELECT_BIT1, SPEED_SELECT_BIT0};
  wire [31:0] cmd_any = SPEED_COMMAND | SPEED_LIMIT;
  // select pins unchanged long enough to settle
  sequence sel_held;
    $stable(sel) [*6];
  endsequence
  // selects off and reference at zero volts
  sequence ref_zero;
    (sel == 2'h0 && ANALOG_MV == 16'h0000) [*6];
  endsequence
  split_cmd_a: assert property (TORQUE_MODE |-> SPEED_COMMAND == 32'h0)
    else $error("command not idle in torque mode");
  split_lim_a: assert property (!TORQUE_MODE |-> SPEED_LIMIT == 32'h0)
    else $error("limit not idle in speed mode");
  valid_up_a: assert property (!$past(SYS_RST) |-> SPEED_COMMAND_VALID)
    else $error("command valid low after reset");
  hold_sel_a: assert property (sel_held ##0 (sel != 2'h0) |-> $stable(cmd_any))
    else $error("internal command moved without select change");
  zero_ref_a: assert property (ref_zero |-> cmd_any == 32'h0)
    else $error("command not zero for zero reference");
  bw_manual_a: assert property (!AUTO_TUNE_ON |-> BANDWIDTH_LEVEL == 4'h0)
    else $error("bandwidth level set in manual tuning");
  bw_range_a: assert property (BANDWIDTH_LEVEL <= 4'h9)
    else $error("bandwidth level beyond ten levels");
  err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("bus error outside access phase");
  apb_ans_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("access phase not answered");
endmodule

bind scss_top scss_asserts chk_u (.CLK, .SYS_RST, .PSEL, .PENABLE, .PREADY,
  .PSLVERR, .SPEED_SELECT_BIT0, .SPEED_SELECT_BIT1, .ANALOG_MV,
  .SPEED_COMMAND, .SPEED_LIMIT, .SPEED_COMMAND_VALID, .TORQUE_MODE,
  .AUTO_TUNE_ON, .BANDWIDTH_LEVEL);

//--- tb/scss_host.sv
// ----
// host driving select pins and reference
// ----
module scss_host (
  input wire logic clk,
  input wire logic slow,
  input wire logic [1:0] want_sel,
  input wire logic signed [15:0] want_mv,
  output logic sel_b0 = 1'b0,
  output logic sel_b1 = 1'b0,
  output logic signed [15:0] ref_mv = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  int lag = 0;
  // apply wanted levels, a few cycles late when slow
  always @(posedge clk) begin
    if (lag > 0) begin
      lag <= lag - 1;
    end else begin
      {sel_b1, sel_b0} <= want_sel;
      // steps left abrupt, the selector applies no smoothing
      ref_mv <= want_mv > 10000 ? 16'sh2710 :
        want_mv < -10000 ? -16'sh2710 : want_mv;
      lag <= slow ? 3 : 0;
    end
  end
endmodule

//--- tb/test_speed_command_source_select.sv
module test_speed_command_source_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, b0, b1, vld, er, TORQUE_MODE, AUTO_TUNE_ON;
  logic [3:0] BANDWIDTH_LEVEL;
  logic [1:0] want = 2'h0;
  logic signed [15:0] mv_w = 16'h0000, mv;
  logic signed [31:0] SPEED_COMMAND, SPEED_LIMIT;
  int seed = 9974, err_total = 0, check_count = 0, zm, tm, mx, i, old;
  int sp [4] = '{0, 0, 0, 0};
  int tbl [10] = '{0, 0, 0, 0, 3000, 0, 0, 4, 0, 0};
  int tw [3] = '{8'h15, 8'h1A, 8'h07};
  int te [3] = '{8'h15, 8'h15, 8'h00};
  scss_top dut_u (.CLK, .SYS_RST, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .SPEED_SELECT_BIT0(b0),
    .SPEED_SELECT_BIT1(b1), .ANALOG_MV(mv), .SPEED_COMMAND, .SPEED_LIMIT,
    .SPEED_COMMAND_VALID(vld), .TORQUE_MODE, .AUTO_TUNE_ON, .BANDWIDTH_LEVEL);
  scss_host host_u (.clk(CLK), .slow, .want_sel(want), .want_mv(mv_w),
    .sel_b0(b0), .sel_b1(b1), .ref_mv(mv));
  // ----
  // clock, helpers and tasks
  // ----
  always #20 CLK = ~CLK;
  function int lim(int v, int m);
    return v > m ? m : v < -m ? -m : v;
  endfunction
  function int exp_cmd(logic [1:0] s, int v);
    if (s != 2'h0) return sp[s];
    return zm ? 0 : v * mx / 10000 * 10;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready seen
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // set pins through the host, then compare both outputs
  task step(input logic [1:0] s, input int v);
    @(posedge CLK);
    want <= s;
    mv_w <= 16'(v);
    repeat (14) @(posedge CLK);
    @(negedge CLK);
    chk(tm ? SPEED_LIMIT : SPEED_COMMAND, exp_cmd(s, lim(v, 10000)));
    chk(tm ? SPEED_COMMAND : SPEED_LIMIT, 0);
    chk(TORQUE_MODE, tm);
    chk(vld, 1'b1);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    close_out;
  end
  // main sequence
  initial begin
    zm = 0;
    tm = 0;
    mx = 3000;
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'b0;
    for (i = 0; i < 10; i++) begin
      apb(12'(i * 4), 1'b0, 32'h0);
      chk(rd, tbl[i]);
      chk(er, i == 9);
    end
    $display("test 1 done");
    for (i = 1; i < 4; i++) begin
      sp[i] = i == 1 ? 70000 : i == 2 ? -70000 : $random(seed) % 60000;
      apb(12'(i * 4 - 4), 1'b1, 32'(sp[i]));
      sp[i] = lim(sp[i], 60000);
      apb(12'(i * 4 - 4), 1'b0, 32'h0);
      chk(rd, sp[i]);
      step(2'(i), 0);
    end
    old = sp[3];
    sp[3] = $random(seed) % 60000;
    apb(12'h008, 1'b1, 32'(sp[3]));
    repeat (6) @(posedge CLK);
    @(negedge CLK);
    chk(SPEED_COMMAND, old);
    step(2'h2, 0);
    step(2'h3, 0);
    $display("test 2 done");
    for (i = 0; i < 16; i++) begin
      zm = $random(seed) & 1;
      tm = $random(seed) & 1;
      mx = $random(seed) & 16383;
      apb(12'h010, 1'b1, 32'(mx));
      mx = lim(mx, 10000);
      apb(12'h00C, 1'b1, 32'(tm * 2 + zm));
      slow <= 1'($random(seed));
      step(2'($random(seed)), $random(seed) % 12000);
    end
    $display("test 3 done");
    for (i = 0; i < 3; i++) begin
      apb(12'h020, 1'b1, 32'(tw[i]));
      @(negedge CLK);
      chk({AUTO_TUNE_ON, BANDWIDTH_LEVEL}, te[i]);
    end
    $display("test 4 done");
    close_out;
  end
endmodule
